// ### aep_regs.sv
/*
 apb register bank for the converter's limit-event publish configuration, interrupt enable mask
 and sticky event status; routes limit events onto sixteen interconnect event channels.
 assumes single clock, event pulses from the converter in the same clock domain, apb master.
*/
//Function
//RULE1: eight upper-limit publish registers sit at 0x198 plus 8 per channel and reset to zero.
//RULE2: an enabled upper-limit event is sent on the event channel named by its index field.
//RULE3: bit 31 of an upper-limit publish register enables (1) or blocks (0) its publishing.
//RULE4: eight lower-limit publish registers sit at 0x19C plus 8 per channel, interleaved.
//RULE5: lower-limit registers hold a channel index in the low bits and an enable at bit 31.
//RULE6: the interrupt enable mask at 0x300 holds the six general event enables in bits 0 to 5.
//RULE7: channel k has its upper-limit enable at bit 6+2k and lower-limit enable at bit 7+2k.
//RULE8: the interrupt enable mask resets to zero so no interrupt fires until enabled.
//RULE9: the interrupt is high while a flagged event is enabled; mask bits 22 to 31 read zero.
`timescale 1ns/100ps
`include "aep_consts.svh"

module aep_regs #(
	parameter int NUM_CH = `AEP_NUM_CH
) (
	input  wire logic                       I_CLK,      // 20 MHz clock
	input  wire logic                       I_RSTN,     // synchronous reset, active low
	input  wire logic                       I_CE,       // clock enable, freezes state when low
	input  wire logic                       I_PSEL,     // apb select
	input  wire logic                       I_PENABLE,  // apb access phase
	input  wire logic                       I_PWRITE,   // apb direction
	input  wire logic [`AEP_ADDR_W-1:0]     I_PADDR,    // apb byte address
	input  wire logic [31:0]                I_PWDATA,   // apb write data
	input  wire logic [3:0]                 I_PSTRB,    // apb byte strobes
	input  wire logic [`AEP_NUM_EV-1:0]     I_EVENTS,   // converter event pulses
	output logic      [31:0]                O_PRDATA,   // apb read data
	output logic                            O_PREADY,   // apb ready
	output logic                            O_PSLVERR,  // apb error, unmapped address
	output logic      [`AEP_NUM_EVCH-1:0]   O_EVT_CH,   // published event channel pulses
	output logic                            O_IRQ       // level interrupt request
);

	localparam int NUM_ENT = 2 * NUM_CH;

	if (NUM_CH < 1 || NUM_CH > `AEP_NUM_CH) begin : g_bad_param
		$error("aep_regs: NUM_CH out of range");
	end

	aep_pkg::aep_state_type   st_ff;
	aep_pkg::aep_state_type   nxt_st;
	aep_pkg::aep_dec_type     dec;
	logic                     dec_hit;
	logic [`AEP_NUM_EVCH-1:0] ent_hit [`AEP_NUM_ENT];

	// one routing term per publish entry; entry 2n is upper, 2n+1 is lower limit of channel n
	for (genvar e = 0; e < `AEP_NUM_ENT; e++) begin : g_ent
		//RULE2: route upper event
		//RULE3: gate by enable
		//RULE5: route lower event
		assign ent_hit[e] = (e < NUM_ENT && st_ff.pub[e].en && I_EVENTS[`AEP_LIM_LSB + e])
			? (`AEP_EVCH_ONE << st_ff.pub[e].idx) : '0;
	end

	// address decode
	always_comb begin
		logic [`AEP_ADDR_W-1:0] rel;
		rel        = I_PADDR - `AEP_OFS_PUB_HI;
		dec        = '0;
		//RULE1: upper registers base
		//RULE4: lower registers interleaved
		dec.pub    = (I_PADDR[1:0] == 2'b00) && (I_PADDR >= `AEP_OFS_PUB_HI)
			&& (rel < `AEP_PUB_SPAN) && (int'(rel[5:2]) < NUM_ENT);
		dec.ent    = rel[5:2];
		//RULE6: mask register offset
		dec.interrupt_enable_mask  = (I_PADDR == `AEP_OFS_INTERRUPT_ENABLE_MASK);
		dec.status = (I_PADDR == `AEP_OFS_STATUS);
		dec_hit    = dec.pub | dec.interrupt_enable_mask | dec.status;
	end

	// zero-wait writes and reads; read data is registered in the setup cycle so that it comes from a flip-flop
	assign O_PREADY  = I_CE & (I_PWRITE | st_ff.rdv);
	assign O_PSLVERR = I_PSEL & I_PENABLE & O_PREADY & ~dec_hit;
	assign O_PRDATA  = st_ff.prdata;
	// a frozen pulse must not be seen again on every stalled cycle
	assign O_EVT_CH  = st_ff.evch & {`AEP_NUM_EVCH{I_CE}};
	//RULE9: interrupt level
	assign O_IRQ     = |(st_ff.status & st_ff.interrupt_enable_mask);

	always_comb begin
		logic [31:0]              wmask;
		logic [31:0]              rdword;
		logic [`AEP_NUM_EV-1:0]   clr;
		logic [`AEP_NUM_EVCH-1:0] route;
		logic                     wr;
		wmask  = {{8{I_PSTRB[3]}}, {8{I_PSTRB[2]}}, {8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};
		rdword = `AEP_RST_WORD;
		clr    = '0;
		route  = '0;
		wr     = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY & dec_hit;
		nxt_st = st_ff;
		if (dec.pub) begin
			//RULE5: field layout
			rdword[`AEP_EN_BIT]        = st_ff.pub[dec.ent].en;
			rdword[`AEP_EVENT_CHANNEL_INDEX_W-1:0]   = st_ff.pub[dec.ent].idx;
		end else if (dec.interrupt_enable_mask) begin
			//RULE9: upper bits zero
			rdword[`AEP_NUM_EV-1:0]    = st_ff.interrupt_enable_mask;
		end else if (dec.status) begin
			rdword[`AEP_NUM_EV-1:0]    = st_ff.status;
		end
		for (int e = 0; e < `AEP_NUM_ENT; e++) begin
			route = route | ent_hit[e];
		end
		if (I_CE) begin
			nxt_st.rdv = I_PSEL & ~(I_PENABLE & O_PREADY);
			if (I_PSEL && !I_PWRITE) begin
				nxt_st.prdata = rdword;
			end
			if (wr && dec.pub) begin
				if (I_PSTRB[0]) begin
					nxt_st.pub[dec.ent].idx = I_PWDATA[`AEP_EVENT_CHANNEL_INDEX_W-1:0];
				end
				if (I_PSTRB[3]) begin
					nxt_st.pub[dec.ent].en = I_PWDATA[`AEP_EN_BIT];
				end
			end
			if (wr && dec.interrupt_enable_mask) begin
				//RULE7: per channel enables
				nxt_st.interrupt_enable_mask = (st_ff.interrupt_enable_mask & ~wmask[`AEP_NUM_EV-1:0])
					| (I_PWDATA[`AEP_NUM_EV-1:0] & wmask[`AEP_NUM_EV-1:0]);
			end
			if (wr && dec.status) begin
				clr = I_PWDATA[`AEP_NUM_EV-1:0] & wmask[`AEP_NUM_EV-1:0];
			end
			// a new event wins over a clear in the same cycle
			nxt_st.status = (st_ff.status & ~clr) | I_EVENTS;
			nxt_st.evch   = route;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RSTN) begin
			//RULE8: all registers to zero
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ---------------------------------------------------------------- checks
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RSTN);

	logic wr_full;
	logic any_en;
	assign wr_full = I_CE & I_PSEL & I_PENABLE & I_PWRITE & O_PREADY & (&I_PSTRB);
	always_comb begin
		any_en = 1'b0;
		for (int e = 0; e < `AEP_NUM_ENT; e++) begin
			any_en = any_en | st_ff.pub[e].en;
		end
	end

	chk_hi_reg_write: assert property ( // RULE1
		wr_full && I_PADDR == `AEP_OFS_PUB_HI + `AEP_OFS_STRIDE
		|=> st_ff.pub[2].en == $past(I_PWDATA[`AEP_EN_BIT])
			&& st_ff.pub[2].idx == $past(I_PWDATA[`AEP_EVENT_CHANNEL_INDEX_W-1:0]))
		else $error("upper-limit publish register of channel 1 not written");

	chk_hi_route: assert property ( // RULE2
		I_CE && I_EVENTS[`AEP_LIM_LSB] && st_ff.pub[0].en
		|=> O_EVT_CH[$past(st_ff.pub[0].idx)] || !I_CE)
		else $error("upper-limit event not published on its channel");

	chk_pub_gate: assert property ( // RULE3
		I_CE && !any_en |=> st_ff.evch == '0)
		else $error("event published while all publishing disabled");

	chk_lo_reg_write: assert property ( // RULE4
		wr_full && I_PADDR == `AEP_OFS_PUB_LO
		|=> st_ff.pub[1].en == $past(I_PWDATA[`AEP_EN_BIT])
			&& st_ff.pub[1].idx == $past(I_PWDATA[`AEP_EVENT_CHANNEL_INDEX_W-1:0]))
		else $error("lower-limit publish register of channel 0 not written");

	chk_lo_route: assert property ( // RULE5
		I_CE && I_EVENTS[`AEP_LIM_LSB + 1] && st_ff.pub[1].en
		|=> st_ff.evch[$past(st_ff.pub[1].idx)])
		else $error("lower-limit event not published on its channel");

	chk_interrupt_enable_mask_read: assert property ( // RULE6
		I_PSEL && I_PENABLE && !I_PWRITE && O_PREADY && I_PADDR == `AEP_OFS_INTERRUPT_ENABLE_MASK
		|-> O_PRDATA == {{(32-`AEP_NUM_EV){1'b0}}, st_ff.interrupt_enable_mask})
		else $error("interrupt enable mask read back wrong");

	chk_interrupt_enable_mask_map: assert property ( // RULE7
		I_CE && I_EVENTS[`AEP_LIM_LSB + 1] && st_ff.interrupt_enable_mask[`AEP_LIM_LSB + 1]
		&& !(I_PSEL && I_PENABLE && I_PWRITE)
		|=> O_IRQ)
		else $error("channel 0 lower-limit enable did not raise the interrupt");

	chk_interrupt_enable_mask_reset: assert property ( // RULE8
		@(posedge I_CLK) disable iff (1'b0) !I_RSTN |=> st_ff.interrupt_enable_mask == '0 && !O_IRQ)
		else $error("interrupt enable mask not cleared by reset");

	chk_irq_masked: assert property ( // RULE9
		I_CE && st_ff.interrupt_enable_mask == '0 && !(I_PSEL && I_PENABLE && I_PWRITE)
		|=> !O_IRQ [*1])
		else $error("interrupt raised with every enable clear");

	chk_set_over_clr: assert property ( // RULE9
		wr_full && I_PADDR == `AEP_OFS_STATUS && I_PWDATA[0] && I_EVENTS[0]
		|=> st_ff.status[0])
		else $error("event lost when cleared in the same cycle");

	chk_read_answer: assert property ( // RULE6
		I_CE && I_PSEL && !I_PENABLE && !I_PWRITE ##1 I_CE && I_PSEL && I_PENABLE
		|-> O_PREADY)
		else $error("read not answered in the access cycle");

	cov_hi_publish: cover property (
		I_CE && I_EVENTS[`AEP_LIM_LSB] && st_ff.pub[0].en ##1 |O_EVT_CH);
	cov_irq_rise: cover property (!O_IRQ ##1 O_IRQ);
	cov_slverr: cover property (O_PSLVERR);
	cov_lo_publish: cover property (
		I_CE && I_EVENTS[`AEP_LIM_LSB + 1] && st_ff.pub[1].en ##1 |O_EVT_CH);

endmodule // aep_regs

// ### aep_consts.svh
/*
 constants of the limit-event publish and interrupt register bank: offsets, field positions,
 sizes and reset values. assumes a 12-bit byte address from the bus slave.
*/
`ifndef AEP_CONSTS_SVH
`define AEP_CONSTS_SVH

`define AEP_NUM_CH     8
`define AEP_NUM_ENT    16
`define AEP_NUM_EV     22
`define AEP_LIM_LSB    6
`define AEP_EVENT_CHANNEL_INDEX_W    4
`define AEP_NUM_EVCH   16
`define AEP_EN_BIT     31
`define AEP_ADDR_W     12
`define AEP_OFS_PUB_HI 12'h198
`define AEP_OFS_PUB_LO 12'h19C
`define AEP_OFS_STRIDE 12'h008
`define AEP_PUB_SPAN   12'h040
`define AEP_OFS_INTERRUPT_ENABLE_MASK  12'h300
`define AEP_OFS_STATUS 12'h310
`define AEP_RST_WORD   32'h0000_0000
`define AEP_EVCH_ONE   16'h0001

`endif

// ### aep_pkg.sv
/*
 types of the limit-event publish and interrupt register bank.
 assumes aep_consts.svh is on the include path.
*/
`include "aep_consts.svh"

package aep_pkg;

	// one publish configuration: enable and target event channel
	typedef struct packed {
		logic                     en;
		logic [`AEP_EVENT_CHANNEL_INDEX_W-1:0]  idx;
	} aep_pub_cfg_type;

	// whole state of the bank
	typedef struct packed {
		aep_pub_cfg_type [`AEP_NUM_ENT-1:0] pub;
		logic [`AEP_NUM_EV-1:0]             interrupt_enable_mask;
		logic [`AEP_NUM_EV-1:0]             status;
		logic [`AEP_NUM_EVCH-1:0]           evch;
		logic [31:0]                        prdata;
		logic                               rdv;
	} aep_state_type;

	// decoded bus access
	typedef struct packed {
		logic       pub;
		logic       interrupt_enable_mask;
		logic       status;
		logic [3:0] ent;
	} aep_dec_type;

endpackage

// ### aep_evt_src.sv
/*
 far-side model: the converter's one-cycle event pulses toward the bank.
 assumes one clock shared with the bank; pulses start just after a rising edge.
*/
`timescale 1ns/100ps
module aep_evt_src (
	input  wire logic        i_clk, // bank clock
	output logic      [21:0] o_ev   // one-cycle event pulses
);
	initial o_ev = '0;
	// one pulse, held for exactly one edge
	task automatic pulse(input int b);
		@(posedge i_clk) o_ev <= 22'h0_0001 << b;
		@(posedge i_clk) o_ev <= '0;
	endtask
endmodule // aep_evt_src

// ### adc_event_publish_irq_regs_tb.sv
/*
 self-checking bench of the publish and interrupt register bank.
 assumes aep_consts.svh on the include path and aep_evt_src compiled first.
*/
`timescale 1ns/100ps
`include "aep_consts.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module adc_event_publish_irq_regs_tb_top;
	logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, v;
	logic        pready, pslverr, irq;
	logic [15:0] evt_ch;
	logic [21:0] ev;
	logic [31:0] q[$];
	int          num_errors = 0, checked = 0, cyc = 0;

	aep_regs aep_regs_inst (.I_CLK(clk), .I_RSTN(rst_n), .I_CE(1'b1), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.I_PSTRB(4'hF), .I_EVENTS(ev), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .O_EVT_CH(evt_ch), .O_IRQ(irq));
	aep_evt_src aep_evt_src_inst (.i_clk(clk), .o_ev(ev));

	initial forever #25 clk = ~clk;

	task automatic end_sim();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// for a read, d is the expected word
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) q.push_back(d);
		@(posedge clk);
		penable <= 1;
		// pready and pslverr are settled by the falling edge of each access cycle
		do @(negedge clk); while (pready !== 1'b1);
		`CHK("pslverr", e, pslverr)
		@(posedge clk);
		psel <= 0;
		penable <= 0;
	endtask

	// watcher: each read or event pulse takes the oldest note
	// outputs are read mid-cycle, away from the edge that updates them
	always @(negedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			num_errors++;
			end_sim();
		end
		if (rst_n && (psel && penable && pready && !pwrite || evt_ch !== '0)) begin
			v = (q.size() > 0) ? q.pop_front() : 32'hDEAD_BEEF;
			`CHK("result", v, (evt_ch !== '0) ? {16'h0000, evt_ch} : prdata)
		end
	end

	initial begin
		int          e;
		logic [31:0] d;
		void'($urandom(24708));
		repeat (4) @(posedge clk);
		rst_n <= 1;
		apb(0, `AEP_OFS_INTERRUPT_ENABLE_MASK, 32'h0000_0000, 0);
		apb(1, `AEP_OFS_INTERRUPT_ENABLE_MASK, 32'hFFFF_FFFF, 0);
		apb(0, `AEP_OFS_INTERRUPT_ENABLE_MASK, 32'h003F_FFFF, 0);
		for (e = 0; e < 22; e++) begin
			apb(1, `AEP_OFS_INTERRUPT_ENABLE_MASK, 32'h0000_0001 << e, 0);
			aep_evt_src_inst.pulse(e ^ 1);
			@(negedge clk);
			`CHK("irq", 1'b0, irq)
			aep_evt_src_inst.pulse(e);
			@(negedge clk);
			`CHK("irq", 1'b1, irq)
			apb(1, `AEP_OFS_STATUS, 32'h003F_FFFF, 0);
			@(negedge clk);
			`CHK("irq", 1'b0, irq)
		end
		for (e = 0; e < 16; e++) begin
			d = $urandom();
			// entry e sits at 0x198 plus 4e and resets to zero
			apb(0, `AEP_OFS_PUB_HI + 12'(4 * e), 32'h0000_0000, 0);
			apb(1, `AEP_OFS_PUB_HI + 12'(4 * e), d, 0);
			// only enable and index are kept
			apb(0, `AEP_OFS_PUB_HI + 12'(4 * e), d & 32'h8000_000F, 0);
			// enabled entry publishes on its index
			if (d[31]) q.push_back(32'h0000_0001 << d[3:0]);
			aep_evt_src_inst.pulse(6 + e);
			repeat (3) @(posedge clk);
		end
		apb(0, 12'h304, 32'h0000_0000, 1);
		apb(1, 12'h1D8, 32'hFFFF_FFFF, 1);
		apb(0, 12'h1D8, 32'h0000_0000, 1);
		repeat (4) @(posedge clk);
		end_sim();
	end
endmodule // adc_event_publish_irq_regs_tb_top
